// >>> design/led_light_control.sv
// LED light unit control: backlight fade, flash timer, sleep, regulators
`timescale 1ns/1ps
`include "led_light_map.svh"
// How it works
// - Backlight level is one of 32 codes
// - Code steps 0.5, then 1, then 2 mA
// - Backlight sinks start disabled after power-up
// - Fade walks applied code one step each
// - Fade step interval 8/16/24/32 ms
// - Flash level 50 to 400 mA, 50 mA steps
// - High trigger pin activates flash directly
// - Trigger held high: serial bits control sink
// - Timer kills only flash sink after 1 s
// - Timer on by default, host may disable
// - Trigger low or cleared bits reset timer
// - Chip enable low: all outputs inactive
// - Chip enable low: registers at defaults
// - Sleep when every LED sink is off
// - Sleep stops clock and pump, bus alive
// - Regulators may run during sleep
// - First regulator 2.5 to 3.3 V
// - Second regulator 1.5 to 1.8 V
// - Pump picks 1x/1.5x/2x, 250 kHz switching
// - Fade field 00=32 01=24 10=16 11=8 ms
// - Fade bit cleared mid-fade jumps to target
// - Tripped flash stays off until trigger low or cleared bits
// - Bus usable 1 ms after chip enable
module led_light_control
  import led_light_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        chip_enable,
  input  wire logic        flash_trigger_pin,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_bl_ctrl,
  input  wire logic        wr_bl_enable,
  input  wire logic        wr_flash_ctrl,
  input  wire logic        wr_reg_ctrl,
  input  wire logic        pump_need_up,
  input  wire logic        pump_can_down,
  output logic [7:0]       bl_ctrl,
  output logic [7:0]       bl_enable,
  output logic [7:0]       flash_ctrl,
  output logic [7:0]       reg_ctrl,
  output logic [4:0]       bl_level_applied,
  output logic [3:0]       bl_sink_on,
  output logic             fade_busy,
  output logic [8:0]       bl_current_halfma,
  output logic             flash_sink_output,
  output logic [8:0]       flash_current_ma,
  output logic             safety_tripped,
  output logic             sleep,
  output logic             core_clock_run,
  output logic             pump_run,
  output pump_mode_t       pump_mode,
  output logic             pump_clk,
  output logic             first_regulator_on,
  output logic [5:0]       first_regulator_dv,
  output logic             second_regulator_on,
  output logic [4:0]       second_regulator_dv,
  output logic             bus_ready
);
  // Backlight code to current in half-milliamp units
  function automatic logic [8:0] bl_halfma(input logic [4:0] code);
    logic [8:0] c;
    c = {4'h0, code};
    if (code <= 5'h17)      bl_halfma = c + 9'h001;
    else if (code <= 5'h1A) bl_halfma = 9'h018 + ((c - 9'h017) << 1);
    else                    bl_halfma = 9'h01E + ((c - 9'h01A) << 2);
  endfunction : bl_halfma

  function automatic logic [7:0] fade_ms(input logic [1:0] rate);
    fade_ms = 8'h20 - {3'h0, rate, 3'h0};
  endfunction : fade_ms

  // Any register write outside chip enable is dropped; defaults hold
  wire en_rst = rst || !chip_enable;
  logic tick;
  ms_ticker u_tick (
    .clock (clock),
    .rst   (en_rst),
    .tick  (tick)
  );

  // Host writes; reserved bits forced to zero on write
  always_ff @(posedge clock) begin
    if (en_rst) begin
      bl_ctrl    <= `BL_CTRL_RESET;
      bl_enable  <= `BL_ENABLE_RESET;
      flash_ctrl <= `FLASH_CTRL_RESET;
      reg_ctrl   <= `REG_CTRL_RESET;
    end else begin
      if (wr_bl_ctrl)    bl_ctrl    <= wr_data;
      if (wr_bl_enable)  bl_enable  <= {4'h0, wr_data[3:0]};
      if (wr_flash_ctrl) flash_ctrl <= {3'h0, wr_data[4:0]};
      if (wr_reg_ctrl)   reg_ctrl   <= {1'b0, wr_data[6:0]};
    end
  end

  wire [4:0] bl_target = bl_ctrl[`BL_LEVEL_LSB +: `BL_LEVEL_W];
  wire       fade_en   = bl_ctrl[`FADE_EN_BIT];
  wire [1:0] fade_rate = bl_ctrl[`FADE_RATE_LSB +: 2];
  wire [7:0] step_ms   = fade_ms(fade_rate);

  // Fade engine; rate changes apply to the interval already under way
  logic [7:0] fade_cnt;
  wire        at_target = (bl_level_applied == bl_target);
  wire        step_due  = tick && (fade_cnt + 8'h01 >= step_ms);
  assign fade_busy = fade_en && !at_target;
  always_ff @(posedge clock) begin
    if (en_rst) begin
      bl_level_applied <= 5'h00;
      fade_cnt         <= 8'h00;
    end else if (!fade_en) begin
      bl_level_applied <= bl_target;
      fade_cnt         <= 8'h00;
    end else if (at_target) begin
      fade_cnt <= 8'h00;
    end else if (step_due) begin
      fade_cnt <= 8'h00;
      if (bl_target > bl_level_applied)
        bl_level_applied <= bl_level_applied + 5'h01;
      else
        bl_level_applied <= bl_level_applied - 5'h01;
    end else if (tick) begin
      fade_cnt <= fade_cnt + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (en_rst) begin
      bl_sink_on        <= 4'h0;
      bl_current_halfma <= 9'h000;
    end else begin
      bl_sink_on        <= bl_enable[3:0];
      bl_current_halfma <= (bl_enable[3:0] != 4'h0) ?
                           bl_halfma(bl_level_applied) : 9'h000;
    end
  end

  // Flash/spotlight: bit0 selects flash (1) or spotlight (0), spotlight code 0 = off
  wire       flash_mode  = flash_ctrl[`FLASH_SPOT_BIT];
  wire [2:0] flash_code  = flash_ctrl[`FLASH_LEVEL_LSB +: `FLASH_LEVEL_W];
  wire       timeout_en  = flash_ctrl[`TIMEOUT_EN_BIT];
  wire       ctrl_off    = (flash_code == 3'h0) && !flash_mode;
  wire [2:0] spot_code   = (flash_code > `SPOT_MAX_CODE) ?
                           `SPOT_MAX_CODE : flash_code;
  wire [2:0] eff_code    = flash_mode ? flash_code : spot_code;
  // Trigger high: sink runs at the programmed level, 50..400 mA; spotlight capped at 250 mA
  wire       want_on     = flash_trigger_pin && !ctrl_off;
  wire       timer_clear = !flash_trigger_pin || ctrl_off;

  flash_state_t fl_state;
  flash_state_t next_fl_state;
  logic [9:0]   on_ms;
  wire          expired = timeout_en && tick &&
                          (on_ms == 10'(`SAFETY_MS - 1));
  always_comb begin
    next_fl_state = fl_state;
    unique case (fl_state)
      FL_IDLE: if (want_on) next_fl_state = FL_ON;
      FL_ON:   if (!want_on) next_fl_state = FL_IDLE;
               else if (expired) next_fl_state = FL_TRIP;
      FL_TRIP: if (timer_clear) next_fl_state = FL_IDLE;
      default: next_fl_state = FL_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (en_rst) begin
      fl_state  <= FL_IDLE;
      on_ms     <= 10'h000;
    end else begin
      fl_state  <= next_fl_state;
      if (fl_state != FL_ON || timer_clear)
        on_ms <= 10'h000;
      else if (tick && timeout_en)
        on_ms <= on_ms + 10'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (en_rst) begin
      flash_sink_output <= 1'b0;
      flash_current_ma  <= 9'h000;
    end else begin
      flash_sink_output <= (fl_state == FL_ON) && want_on;
      flash_current_ma  <= ((fl_state == FL_ON) && want_on) ?
                           9'(({6'h00, eff_code} + 9'h001) * 9'd50) :
                           9'h000;
    end
  end
  assign safety_tripped = (fl_state == FL_TRIP);

  // Sleep when no sink conducts; bus and regulators unaffected
  wire leds_off = (bl_sink_on == 4'h0) && !flash_sink_output;
  always_ff @(posedge clock) begin
    if (en_rst) sleep <= 1'b1;
    else        sleep <= leds_off;
  end
  assign core_clock_run = chip_enable && !sleep;
  assign pump_run       = chip_enable && !sleep;

  pump_mode_select u_pump (
    .clock    (clock),
    .rst      (en_rst),
    .run      (pump_run),
    .need_up  (pump_need_up),
    .can_down (pump_can_down),
    .mode     (pump_mode),
    .pump_clk (pump_clk)
  );

  // Regulator codes: 0 = off, n = lowest + (n-1)*100 mV, clamped at top
  wire [3:0] r1_code = reg_ctrl[`REG1_LEVEL_LSB +: `REG1_LEVEL_W];
  wire [2:0] r2_code = reg_ctrl[`REG2_LEVEL_LSB +: `REG2_LEVEL_W];
  wire [3:0] r1_sat  = (r1_code > 4'(`REG1_MAX_CODE + 1)) ?
                       4'(`REG1_MAX_CODE + 1) : r1_code;
  wire [2:0] r2_sat  = (r2_code > 3'(`REG2_MAX_CODE + 1)) ?
                       3'(`REG2_MAX_CODE + 1) : r2_code;
  always_ff @(posedge clock) begin
    if (en_rst) begin
      first_regulator_on  <= 1'b0;
      first_regulator_dv  <= 6'h00;
      second_regulator_on <= 1'b0;
      second_regulator_dv <= 5'h00;
    end else begin
      // Independent of sleep
      first_regulator_on  <= (r1_code != 4'h0);
      first_regulator_dv  <= (r1_code == 4'h0) ? 6'h00 :
                             6'(6'd25 + {2'h0, r1_sat} - 6'd1);
      second_regulator_on <= (r2_code != 3'h0);
      second_regulator_dv <= (r2_code == 3'h0) ? 5'h00 :
                             5'(5'd15 + {2'h0, r2_sat} - 5'd1);
    end
  end

  // Bus start-up after chip enable
  logic [1:0] up_ms;
  always_ff @(posedge clock) begin
    if (en_rst) begin
      up_ms     <= 2'h0;
      bus_ready <= 1'b0;
    end else if (!bus_ready && tick) begin
      up_ms     <= up_ms + 2'h1;
      bus_ready <= (up_ms + 2'h1 >= 2'(`STARTUP_MS));
    end
  end
endmodule : led_light_control

// >>> design/ms_ticker.sv
// Millisecond tick generator
`timescale 1ns/1ps
`include "led_light_map.svh"
module ms_ticker (
  input  wire logic        clock,
  input  wire logic        rst,
  output logic             tick
);
  localparam int unsigned TC = `TICK_CYCLES;
  logic [15:0] count;
  wire         wrap = (count == 16'(TC - 1));
  always_ff @(posedge clock) begin
    if (rst) begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end else begin
      count <= wrap ? 16'h0000 : count + 16'h0001;
      tick  <= wrap;
    end
  end
endmodule : ms_ticker

// >>> design/pump_mode_select.sv
// Charge pump mode choice with hysteresis and 250 kHz switching clock
`timescale 1ns/1ps
`include "led_light_map.svh"
module pump_mode_select
  import led_light_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic        need_up,
  input  wire logic        can_down,
  output pump_mode_t       mode,
  output logic             pump_clk
);
  localparam int unsigned HALF = `PUMP_HALF_CYCLES;
  pump_mode_t next_mode;
  logic [5:0] div;
  wire        div_wrap = (div == 6'(HALF - 1));
  // Up only on demand, down only on clear headroom: the gap is the hysteresis
  always_comb begin
    next_mode = mode;
    unique case (mode)
      PUMP_1X:  if (need_up) next_mode = PUMP_15X;
      PUMP_15X: if (need_up) next_mode = PUMP_2X;
                else if (can_down) next_mode = PUMP_1X;
      PUMP_2X:  if (can_down) next_mode = PUMP_15X;
      default:  next_mode = PUMP_1X;
    endcase
  end
  always_ff @(posedge clock) begin
    if (rst || !run) begin
      mode     <= PUMP_1X;
      div      <= 6'h00;
      pump_clk <= 1'b0;
    end else begin
      mode <= next_mode;
      div  <= div_wrap ? 6'h00 : div + 6'h01;
      // Drop the switch phase at once in 1x, not at the next wrap
      if (mode == PUMP_1X) begin
        pump_clk <= 1'b0;
      end else if (div_wrap) begin
        pump_clk <= ~pump_clk;
      end
    end
  end
endmodule : pump_mode_select

// >>> include/led_light_map.svh
// Register layout, reset values and timing counts for the LED light unit
`ifndef LED_LIGHT_MAP_SVH
`define LED_LIGHT_MAP_SVH
`define BL_LEVEL_LSB        0
`define BL_LEVEL_W          5
`define FADE_EN_BIT         5
`define FADE_RATE_LSB       6
`define SINK_EN_W           4
`define FLASH_SPOT_BIT      0
`define FLASH_LEVEL_LSB     1
`define FLASH_LEVEL_W       3
`define TIMEOUT_EN_BIT      4
`define REG1_LEVEL_LSB      0
`define REG1_LEVEL_W        4
`define REG2_LEVEL_LSB      4
`define REG2_LEVEL_W        3
`define BL_CTRL_RESET       8'h00
`define BL_ENABLE_RESET     8'h00
`define FLASH_CTRL_RESET    8'h10
`define REG_CTRL_RESET      8'h00
`define REG1_MAX_CODE       4'h8
`define REG2_MAX_CODE       3'h3
`define SPOT_MAX_CODE       3'h4
`define CLOCK_HZ            25000000
`define TICK_US             1000
`define TICK_CYCLES         ((`CLOCK_HZ / 1000000) * `TICK_US)
`define SAFETY_MS           1000
`define STARTUP_MS          1
`define PUMP_HZ             250000
`define PUMP_HALF_CYCLES    (`CLOCK_HZ / `PUMP_HZ / 2)
`endif

// >>> include/led_light_pkg.sv
// Types shared by the LED light unit
package led_light_pkg;
  typedef enum logic [2:0] {
    PUMP_1X  = 3'b001,
    PUMP_15X = 3'b010,
    PUMP_2X  = 3'b100
  } pump_mode_t;
  typedef enum logic [2:0] {
    FL_IDLE  = 3'b001,
    FL_ON    = 3'b010,
    FL_TRIP  = 3'b100
  } flash_state_t;
endpackage : led_light_pkg

// >>> tb/host_model.sv
// Host model issuing register writes
`timescale 1ns/1ps
module host_model #(
  parameter logic [3:0] ATTACHED = 4'h7
) (
  input  wire logic       clock,
  input  wire logic       bus_ready,
  input  wire logic       fade_busy,
  input  wire logic [7:0] bl_ctrl,
  output logic [7:0]      wr_data,
  output logic [3:0]      wr_sel
);
  initial begin
    wr_data = 8'hA5;
    wr_sel  = 4'h0;
  end
  task automatic write_reg(input logic [1:0] sel, input logic [7:0] data);
    logic [7:0] d;
    int n;
    d = data;
    n = 0;
    while (bus_ready !== 1'b1 && n < 30000) begin
      @(posedge clock);
      n++;
    end
    if (sel == 2'h1) d[3:0] = d[3:0] & ATTACHED;
    if (sel == 2'h0 && fade_busy === 1'b1 && d[5]) d[4:0] = bl_ctrl[4:0];
    @(posedge clock);
    #1;
    wr_data = d;
    wr_sel[sel] = 1'b1;
    @(posedge clock);
    #1;
    wr_sel = 4'h0;
    // Released data lines show junk, not the last value
    wr_data = ~d;
  endtask : write_reg
endmodule : host_model

// >>> tb/led_light_assertions.sv
// Port assertions for the LED light unit
`timescale 1ns/1ps
module led_light_checker
  import led_light_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       chip_enable,
  input wire logic       flash_trigger_pin,
  input wire logic [7:0] bl_ctrl,
  input wire logic [7:0] bl_enable,
  input wire logic [7:0] flash_ctrl,
  input wire logic [7:0] reg_ctrl,
  input wire logic [4:0] bl_level_applied,
  input wire logic [3:0] bl_sink_on,
  input wire logic       flash_sink_output,
  input wire logic       safety_tripped,
  input wire logic       sleep,
  input wire logic       pump_run,
  input wire pump_mode_t pump_mode,
  input wire logic       pump_clk
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence flash_held;
    (flash_trigger_pin && flash_ctrl[0] && chip_enable
     && !safety_tripped)[*3];
  endsequence
  sequence fade_moved;
    bl_level_applied != $past(bl_level_applied) && bl_ctrl[5]
    && $past(bl_ctrl[5]);
  endsequence
  regs_default_a: assert property (
    !chip_enable |=> {bl_ctrl, bl_enable, flash_ctrl, reg_ctrl} == 32'h1000)
    else $error("registers not at defaults");
  outputs_off_a: assert property (
    !chip_enable |=> !flash_sink_output && bl_sink_on == 4'h0 && sleep)
    else $error("outputs active while disabled");
  pump_gate_a: assert property (pump_run == (chip_enable && !sleep))
    else $error("pump run not gated by sleep");
  sleep_entry_a: assert property (
    (bl_sink_on == 4'h0 && !flash_sink_output)[*2] |-> sleep)
    else $error("no sleep with all sinks off");
  fade_step_a: assert property (fade_moved |->
    5'(bl_level_applied - $past(bl_level_applied)) == 5'h01
    || 5'($past(bl_level_applied) - bl_level_applied) == 5'h01)
    else $error("fade moved more than one code");
  fade_cancel_a: assert property (
    $fell(bl_ctrl[5]) |=> bl_level_applied == bl_ctrl[4:0])
    else $error("fade cancel did not jump");
  flash_on_a: assert property (flash_held |-> flash_sink_output)
    else $error("trigger did not light flash");
  flash_off_a: assert property (
    (!flash_trigger_pin)[*3] |-> !flash_sink_output)
    else $error("flash lit with trigger low");
  trip_off_a: assert property (safety_tripped[*2] |-> !flash_sink_output)
    else $error("flash lit after trip");
  pump_idle_a: assert property ((pump_mode == PUMP_1X)[*3] |-> !pump_clk)
    else $error("pump switching in 1x");
endmodule : led_light_checker
bind led_light_control led_light_checker u_chk (.clock, .rst, .chip_enable,
  .flash_trigger_pin, .bl_ctrl, .bl_enable, .flash_ctrl, .reg_ctrl,
  .bl_level_applied, .bl_sink_on, .flash_sink_output, .safety_tripped,
  .sleep, .pump_run, .pump_mode, .pump_clk);

// >>> tb/test_led_light_control.sv
// Self-checking bench for the LED light unit
`timescale 1ns/1ps
module test_led_light_control;
  import led_light_pkg::*;
  logic clock = 0, rst = 1, chip_enable = 1, flash_trigger_pin = 0;
  logic pump_need_up = 0, pump_can_down = 0;
  logic [7:0] wr_data, bl_ctrl, bl_enable, flash_ctrl, reg_ctrl;
  logic [7:0] rnd = 8'h19;
  logic [3:0] wr_sel, bl_sink_on;
  logic [4:0] bl_level_applied, second_regulator_dv;
  logic [5:0] first_regulator_dv;
  logic [8:0] bl_current_halfma, flash_current_ma;
  logic fade_busy, flash_sink_output, sleep, pump_run, bus_ready;
  logic first_regulator_on, second_regulator_on;
  logic safety_tripped, core_clock_run, pump_clk;
  logic [2:0] pump_mode;
  int num_errors = 0, num_checks = 0, n, c, m, on, ma, r1, r2;

  led_light_control u_led_light_control (.clock, .rst, .chip_enable,
    .flash_trigger_pin, .wr_data, .wr_bl_ctrl(wr_sel[0]),
    .wr_bl_enable(wr_sel[1]), .wr_flash_ctrl(wr_sel[2]),
    .wr_reg_ctrl(wr_sel[3]), .pump_need_up, .pump_can_down, .bl_ctrl,
    .bl_enable, .flash_ctrl, .reg_ctrl, .bl_level_applied, .bl_sink_on,
    .fade_busy, .bl_current_halfma, .flash_sink_output, .flash_current_ma,
    .safety_tripped, .sleep, .core_clock_run, .pump_run, .pump_mode,
    .pump_clk, .first_regulator_on, .first_regulator_dv,
    .second_regulator_on, .second_regulator_dv, .bus_ready);
  host_model u_host (.clock, .bus_ready, .fade_busy, .bl_ctrl, .wr_data,
    .wr_sel);

  always #20 clock = ~clock;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  always @(posedge clock) begin
    #1;
    rnd = lfsr(rnd);
    pump_need_up = rnd[0];
    pump_can_down = rnd[1];
  end

  // Half-milliamp units: fine, then 1 mA, then 2 mA steps
  function automatic int bl_half(input int k);
    return k < 24 ? k + 1 : (k < 27 ? 2 * k - 22 : 4 * k - 74);
  endfunction : bl_half
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask : settle
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  initial begin
    repeat (80000) @(posedge clock);
    num_errors++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge clock);
    #1;
    rst = 0;
    check("defaults", {bl_ctrl, bl_enable, flash_ctrl, reg_ctrl}, 32'h1000);
    check("sinks idle", {bl_sink_on, sleep}, 5'h01);
    n = 0;
    while (bus_ready !== 1'b1 && n < 30000) begin
      @(posedge clock);
      n++;
    end
    check("startup", n > 24000 && n < 25100, 1);
    u_host.write_reg(2'h1, 8'h0F);
    settle();
    check("sinks on", {bl_sink_on, sleep}, 5'h0E);
    for (c = 0; c < 32; c++) begin
      u_host.write_reg(2'h0, c[7:0]);
      settle();
      check("bl current", {bl_level_applied, bl_current_halfma},
            (c << 9) | bl_half(c));
    end
    u_host.write_reg(2'h0, 8'hE2);
    settle();
    check("fade start", {fade_busy, bl_level_applied}, 6'h3F);
    u_host.write_reg(2'h0, 8'h02);
    settle();
    check("fade cancel", {fade_busy, bl_level_applied}, 6'h02);
    u_host.write_reg(2'h1, 8'h00);
    for (n = 0; n < 16; n++) begin
      u_host.write_reg(2'h3, {1'b0, n[2:0], n[3:0]});
      settle();
      r1 = n == 0 ? 0 : (n > 8 ? 33 : 24 + n);
      r2 = n[2:0] == 0 ? 0 : (n[2:0] > 3 ? 18 : 14 + n[2:0]);
      check("regulators", {sleep, first_regulator_on, first_regulator_dv,
            second_regulator_on, second_regulator_dv}, (1 << 13) |
            ((n != 0) << 12) | (r1 << 6) | ((r2 != 0) << 5) | r2);
    end
    flash_trigger_pin = 1;
    for (m = 0; m < 2; m++) begin
      for (c = 0; c < 8; c++) begin
        u_host.write_reg(2'h2, 8'h10 | (c << 1) | m);
        settle();
        on = m == 1 || c != 0;
        ma = (m == 0 && c > 4) ? 250 : (c + 1) * 50;
        check("flash out", {flash_sink_output, sleep}, {on[0], !on[0]});
        if (on != 0) check("flash ma", flash_current_ma, ma);
        check("clock run", {core_clock_run, pump_run}, {2{on[0]}});
        check("pump onehot", $onehot(pump_mode), 1);
      end
    end
    flash_trigger_pin = 0;
    settle();
    check("trigger low", flash_sink_output, 1'b0);
    u_host.write_reg(2'h1, 8'h0F);
    u_host.write_reg(2'h3, 8'h11);
    flash_trigger_pin = 1;
    settle();
    chip_enable = 0;
    settle();
    check("disabled regs", {bl_ctrl, bl_enable, flash_ctrl, reg_ctrl},
          32'h1000);
    check("disabled outs", {bl_sink_on, flash_sink_output, first_regulator_on,
          second_regulator_on, sleep, pump_run}, 9'h002);
    check("pump idle", {safety_tripped, core_clock_run, pump_clk, pump_mode},
          6'h01);
    chip_enable = 1;
    flash_trigger_pin = 0;
    u_host.write_reg(2'h1, 8'h0F);
    settle();
    check("re-enabled", bl_sink_on, 4'h7);
    final_report();
  end
endmodule : test_led_light_control
